// [cfg_access_map.svh]
// constants for the configuration space local access port
`ifndef CFG_ACCESS_MAP_SVH
`define CFG_ACCESS_MAP_SVH

`define CFG_ADDR_W 12
`define CFG_DATA_W 32
`define CFG_NUM_PF 2
`define CFG_NUM_VF 4
`define CFG_PF_W 1
`define CFG_VF_W 11
`define CFG_REG_WORDS 64
`define CFG_IDX_W 6
// word index and writable mask of the command/status word
`define CFG_CMD_IDX 6'h01
`define CFG_CMD_WMASK 32'h0000_0547
// word index and writable mask of the device control word
`define CFG_DEVCTL_IDX 6'h1e
`define CFG_DEVCTL_WMASK 32'h0000_7fff
// header log words, fully writable
`define CFG_HDRLOG_FIRST 6'h07
`define CFG_HDRLOG_LAST 6'h0a
// identity word index and reset value of stored bits
`define CFG_ID_IDX 6'h00
`define CFG_STORE_RESET 32'h0000_0000
// hard reset controller clear length
`define CFG_CLK_MHZ 100
`define CFG_HARD_RST_NS 200
`define CFG_HARD_RST_CYC ((`CFG_HARD_RST_NS * `CFG_CLK_MHZ + 999) / 1000)
`define CFG_HARD_CNT_W 8

`endif

// [cfg_access_pkg.sv]
// types shared by both ends of the configuration access port
package cfg_access_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_RELEASE} port_state_e;
  typedef enum logic [1:0] {RQ_IDLE, RQ_WAIT, RQ_DONE} req_state_e;
endpackage

// [cfg_access_if.sv]
// link between the requester and the configuration space port
`timescale 1ns/10ps
`include "cfg_access_map.svh"
interface cfg_access_if;
  logic rden;
  logic wren;
  logic [`CFG_ADDR_W-1:0] addr;
  logic [`CFG_PF_W-1:0] cfg_phys_func_sel;
  logic cfg_target_is_virtual;
  logic [`CFG_VF_W-1:0] cfg_virt_func_offset;
  logic [`CFG_DATA_W-1:0] din;
  logic [`CFG_DATA_W-1:0] dout;
  logic ack;
  logic ready;

  modport device (
    input rden, wren, addr, cfg_phys_func_sel, cfg_target_is_virtual, cfg_virt_func_offset, din,
    output dout, ack, ready
  );
  modport requester (
    output rden, wren, addr, cfg_phys_func_sel, cfg_target_is_virtual, cfg_virt_func_offset, din,
    input dout, ack, ready
  );
endinterface

// [sync2.sv]
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// [cfg_space_port.sv]
// configuration space local access port, device end
//
// Notes on behaviour
// - acknowledge pulses one cycle per completed access
// - read data valid from acknowledge onward
// - 12-bit byte address, low two bits ignored
// - function number selects physical function or parent
// - virtual target comes with its offset
// - offset below parent's virtual function count
// - writes change writable bits only
// - everything readable, read-write fields writable
// - header log words accept full writes
// - core reset asynchronous, clears everything
// - core reset derived from pin reset
// - hard controller fires on image loaded while config over link set
// - hard-controller reset acts as fixed pulse
// - pin reset clears datapath and control
`timescale 1ns/10ps
`include "cfg_access_map.svh"
module cfg_space_port #(
  parameter int NUM_PF = `CFG_NUM_PF,
  parameter int NUM_VF = `CFG_NUM_VF,
  parameter int REG_WORDS = `CFG_REG_WORDS,
  parameter logic [31:0] ID_VALUE = 32'h0001_0002 // arbitrary identity value
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic PIN_PERST_N_I,
  input wire logic CONFIG_OVER_LINK_I,
  input wire logic IMAGE_LOADED_I,
  output logic RESET_ACTIVE_O,
  cfg_access_if.device port
);
  localparam int NUM_FUNC = NUM_PF + NUM_PF * NUM_VF;
  localparam int DEPTH = NUM_FUNC * REG_WORDS;
  localparam int FLAT_W = $clog2(DEPTH);
  localparam logic [`CFG_HARD_CNT_W-1:0] HARD_CYC = `CFG_HARD_CNT_W'(`CFG_HARD_RST_CYC);

  cfg_access_pkg::port_state_e state;
  logic [2:0] pins_s;
  logic perst_n_s;
  logic col_s;
  logic img_s;
  logic img_prev;
  logic [`CFG_HARD_CNT_W-1:0] hard_cnt;
  logic clear;
  logic hit;
  logic op_read;
  logic [`CFG_IDX_W-1:0] idx;
  logic [FLAT_W-1:0] flat;
  logic [31:0] wdata;
  logic [31:0] store [DEPTH];

  // writable bits of a word index
  function automatic logic [31:0] wr_mask(input logic [`CFG_IDX_W-1:0] i);
    if (i >= `CFG_HDRLOG_FIRST && i <= `CFG_HDRLOG_LAST) begin
      wr_mask = 32'hffff_ffff;
    end else if (i == `CFG_CMD_IDX) begin
      wr_mask = `CFG_CMD_WMASK;
    end else if (i == `CFG_DEVCTL_IDX) begin
      wr_mask = `CFG_DEVCTL_WMASK;
    end else begin
      wr_mask = 32'h0000_0000;
    end
  endfunction

  // fixed read-only contents of a word index
  function automatic logic [31:0] ro_value(input logic [`CFG_IDX_W-1:0] i);
    ro_value = (i == `CFG_ID_IDX) ? ID_VALUE : 32'h0000_0000;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  sync2 #(.W(3)) pin_sync (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .d_i({PIN_PERST_N_I, CONFIG_OVER_LINK_I, IMAGE_LOADED_I}),
    .q_o(pins_s)
  );
  assign perst_n_s = pins_s[2];
  assign col_s = pins_s[1];
  assign img_s = pins_s[0];

  // image-loaded edge with config over link set starts the hard controller, pin reset not involved
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      img_prev <= 1'b0;
      hard_cnt <= '0;
    end else begin
      img_prev <= img_s;
      if (col_s && img_s && !img_prev) begin
        hard_cnt <= HARD_CYC;
      end else if (hard_cnt != '0) begin
        hard_cnt <= hard_cnt - `CFG_HARD_CNT_W'(1);
      end
    end
  end

  assign clear = !perst_n_s || (hard_cnt != '0);

  // reset status shown to the requester
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RESET_ACTIVE_O <= 1'b1;
      port.ready <= 1'b0;
    end else begin
      RESET_ACTIVE_O <= clear;
      port.ready <= !clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request capture

  // latch the decoded target when a request is taken
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      hit <= 1'b0;
      op_read <= 1'b0;
      idx <= '0;
      flat <= '0;
      wdata <= '0;
    end else if (state == cfg_access_pkg::ST_IDLE && (port.rden || port.wren)) begin
      op_read <= port.rden; // read wins if both are raised
      idx <= port.addr[`CFG_IDX_W+1:2];
      wdata <= port.din;
      hit <= (int'(port.addr[11:2]) < REG_WORDS) && (int'(port.cfg_phys_func_sel) < NUM_PF)
             && (!port.cfg_target_is_virtual
                 || int'(port.cfg_virt_func_offset) < NUM_VF);
      if (port.cfg_target_is_virtual) begin
        flat <= FLAT_W'((NUM_PF + int'(port.cfg_phys_func_sel) * NUM_VF
                + int'(port.cfg_virt_func_offset)) * REG_WORDS
                + int'(port.addr[`CFG_IDX_W+1:2]));
      end else begin
        flat <= FLAT_W'(int'(port.cfg_phys_func_sel) * REG_WORDS
                + int'(port.addr[`CFG_IDX_W+1:2]));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequence

  // idle, one access cycle, then wait for the enables to drop
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= cfg_access_pkg::ST_IDLE;
    end else if (clear) begin
      state <= cfg_access_pkg::ST_IDLE;
    end else begin
      case (state)
        cfg_access_pkg::ST_IDLE: begin
          if (port.rden || port.wren) begin
            state <= cfg_access_pkg::ST_ACCESS;
          end
        end
        cfg_access_pkg::ST_ACCESS: begin
          state <= cfg_access_pkg::ST_RELEASE;
        end
        cfg_access_pkg::ST_RELEASE: begin
          if (!port.rden && !port.wren) begin
            state <= cfg_access_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= cfg_access_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // acknowledge for the single access cycle
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      port.ack <= 1'b0;
    end else begin
      port.ack <= (state == cfg_access_pkg::ST_ACCESS) && !clear;
    end
  end

  // read data, held until the next read or until clear zeroes it
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      port.dout <= '0;
    end else if (clear) begin
      port.dout <= '0;
    end else if (state == cfg_access_pkg::ST_ACCESS && op_read) begin
      port.dout <= hit ? (store[flat] | ro_value(idx)) : 32'h0000_0000;
    end
  end

  // stored writable bits of every function
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= `CFG_STORE_RESET;
      end
    end else if (clear) begin
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= `CFG_STORE_RESET;
      end
    end else if (state == cfg_access_pkg::ST_ACCESS && !op_read && hit) begin
      store[flat] <= (store[flat] & ~wr_mask(idx)) | (wdata & wr_mask(idx));
    end
  end
endmodule

// [cfg_space_requester.sv]
// configuration space access requester, application end
`timescale 1ns/10ps
`include "cfg_access_map.svh"
module cfg_space_requester #(
  parameter int NUM_PF = `CFG_NUM_PF,
  parameter int NUM_VF = `CFG_NUM_VF
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic PIN_PERST_N_I,
  input wire logic USE_SOFT_RESET_I,
  input wire logic SOFT_RSTN_I,
  output logic CORE_RSTN_O,
  input wire logic REQ_VALID_I,
  input wire logic REQ_WRITE_I,
  input wire logic [`CFG_ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [`CFG_PF_W-1:0] REQ_PF_I,
  input wire logic REQ_VIRTUAL_I,
  input wire logic [`CFG_VF_W-1:0] REQ_VF_I,
  input wire logic [`CFG_DATA_W-1:0] REQ_WDATA_I,
  output logic REQ_READY_O,
  output logic RESP_VALID_O,
  output logic RESP_ERROR_O,
  output logic [`CFG_DATA_W-1:0] RESP_DATA_O,
  cfg_access_if.requester port
);
  cfg_access_pkg::req_state_e state;
  logic [1:0] rst_s;
  logic take;
  logic bad;

  sync2 #(.W(2)) rst_sync (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .d_i({PIN_PERST_N_I, SOFT_RSTN_I}),
    .q_o(rst_s)
  );

  // core reset from pin, optionally combined with soft reset
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CORE_RSTN_O <= 1'b0;
    end else begin
      CORE_RSTN_O <= USE_SOFT_RESET_I ? (rst_s[1] & rst_s[0]) : rst_s[1];
    end
  end

  // requests wait for the port to report out of reset
  assign take = REQ_VALID_I && REQ_READY_O;
  assign bad = (int'(REQ_PF_I) >= NUM_PF) || (REQ_VIRTUAL_I && int'(REQ_VF_I) >= NUM_VF);

  ////////////////////////////////////////////////////////////////////////////
  // request sequence

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= cfg_access_pkg::RQ_IDLE;
    end else begin
      case (state)
        cfg_access_pkg::RQ_IDLE: begin
          if (take && !bad) begin
            state <= cfg_access_pkg::RQ_WAIT;
          end
        end
        cfg_access_pkg::RQ_WAIT: begin
          if (port.ack) begin
            state <= cfg_access_pkg::RQ_IDLE;
          end else if (!port.ready) begin
            state <= cfg_access_pkg::RQ_IDLE; // port reset mid-access
          end
        end
        default: begin
          state <= cfg_access_pkg::RQ_IDLE;
        end
      endcase
    end
  end

  // ready only when idle and port out of reset
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      REQ_READY_O <= 1'b0;
    end else begin
      REQ_READY_O <= port.ready && !take && (state == cfg_access_pkg::RQ_IDLE
                     || (state == cfg_access_pkg::RQ_WAIT && port.ack));
    end
  end

  // request lines held from take until acknowledge or until the port drops ready
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      port.rden <= 1'b0;
      port.wren <= 1'b0;
      port.addr <= '0;
      port.cfg_phys_func_sel <= '0;
      port.cfg_target_is_virtual <= 1'b0;
      port.cfg_virt_func_offset <= '0;
      port.din <= '0;
    end else if (take && !bad) begin
      port.rden <= !REQ_WRITE_I;
      port.wren <= REQ_WRITE_I;
      port.addr <= {REQ_ADDR_I[11:2], 2'h0};
      port.cfg_phys_func_sel <= REQ_PF_I;
      port.cfg_target_is_virtual <= REQ_VIRTUAL_I;
      port.cfg_virt_func_offset <= REQ_VIRTUAL_I ? REQ_VF_I : '0;
      port.din <= REQ_WDATA_I;
    end else if (port.ack || !port.ready) begin
      port.rden <= 1'b0;
      port.wren <= 1'b0;
    end
  end

  // one-cycle response, data captured with the acknowledge
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RESP_VALID_O <= 1'b0;
      RESP_ERROR_O <= 1'b0;
      RESP_DATA_O <= '0;
    end else begin
      RESP_VALID_O <= (take && bad) || (state == cfg_access_pkg::RQ_WAIT && port.ack);
      RESP_ERROR_O <= take && bad;
      if (state == cfg_access_pkg::RQ_WAIT && port.ack && port.rden) begin
        RESP_DATA_O <= port.dout;
      end
    end
  end
endmodule

// [cfg_access_link_assertions.sv]
// assertions on the configuration access link between the two ends
`timescale 1ns/10ps
`include "cfg_access_map.svh"
module cfg_access_link_checker #(
  parameter int NUM_VF = `CFG_NUM_VF
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic rden,
  input wire logic wren,
  input wire logic [`CFG_ADDR_W-1:0] addr,
  input wire logic [`CFG_PF_W-1:0] cfg_phys_func_sel,
  input wire logic cfg_target_is_virtual,
  input wire logic [`CFG_VF_W-1:0] cfg_virt_func_offset,
  input wire logic [`CFG_DATA_W-1:0] din,
  input wire logic [`CFG_DATA_W-1:0] dout,
  input wire logic ack,
  input wire logic ready
);
  // either enable counts as a request
  wire logic req = rden | wren;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (ack |-> $past(req, 2))
    else $error("ack without request two cycles before");
  a_ack_fixed_delay: assert property ($rose(req) && ready ##1 ready ##1 ready |-> ack)
    else $error("ack missing two cycles after request");
  a_dout_holds: assert property (!ack && ready |-> $stable(dout))
    else $error("read data changed without ack");
  a_no_ack_clear: assert property (!ready |-> !ack)
    else $error("ack during clear");
  a_one_enable: assert property (!(rden && wren))
    else $error("both enables high");
  a_held_request: assert property (req && !ack |=> !req || ($stable(addr)
    && $stable(din) && $stable(cfg_phys_func_sel) && $stable(cfg_target_is_virtual)
    && $stable(cfg_virt_func_offset)))
    else $error("request lines changed before ack");
  a_drop_after_ack: assert property (ack |=> !req)
    else $error("enable still high after ack");
  a_vf_in_range: assert property (req && cfg_target_is_virtual
    |-> int'(cfg_virt_func_offset) < NUM_VF)
    else $error("virtual offset out of range");
  a_low_addr_zero: assert property (req |-> addr[1:0] == 2'h0)
    else $error("low address bits not zero");
endmodule

// [config_space_local_access_port_test.sv]
// self-checking bench joining requester and port across the access link
`timescale 1ns/10ps
`include "cfg_access_map.svh"
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module config_space_local_access_port_test;
  localparam logic [31:0] ID_WORD = 32'h0000_5a5a; // arbitrary identity value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pin_n = 1'b1;
  logic col = 1'b0;
  logic img = 1'b0;
  logic use_soft = 1'b0;
  logic soft_n = 1'b1;
  logic valid = 1'b0;
  logic write = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [0:0] pf = 1'h0;
  logic virt = 1'b0;
  logic [10:0] vf = 11'h000;
  logic [31:0] wdata = 32'h0;
  logic core_n, rst_act, rdy, rv, rerr;
  logic [31:0] rdata;
  int n_checks = 0;
  int n_mismatch = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // both ends face each other across the link
  cfg_access_if u_cfg_access_if ();
  cfg_space_port #(.ID_VALUE(ID_WORD)) u_cfg_space_port (.REF_CLK_I(clk), .RSTN_I(core_n),
    .PIN_PERST_N_I(pin_n), .CONFIG_OVER_LINK_I(col), .IMAGE_LOADED_I(img),
    .RESET_ACTIVE_O(rst_act), .port(u_cfg_access_if));
  cfg_space_requester u_cfg_space_requester (.REF_CLK_I(clk), .RSTN_I(rstn),
    .PIN_PERST_N_I(pin_n), .USE_SOFT_RESET_I(use_soft), .SOFT_RSTN_I(soft_n),
    .CORE_RSTN_O(core_n), .REQ_VALID_I(valid), .REQ_WRITE_I(write), .REQ_ADDR_I(addr),
    .REQ_PF_I(pf), .REQ_VIRTUAL_I(virt), .REQ_VF_I(vf), .REQ_WDATA_I(wdata),
    .REQ_READY_O(rdy), .RESP_VALID_O(rv), .RESP_ERROR_O(rerr), .RESP_DATA_O(rdata),
    .port(u_cfg_access_if));
  cfg_access_link_checker u_cfg_access_link_checker (.REF_CLK_I(clk), .RSTN_I(core_n),
    .rden(u_cfg_access_if.rden), .wren(u_cfg_access_if.wren), .addr(u_cfg_access_if.addr),
    .cfg_phys_func_sel(u_cfg_access_if.cfg_phys_func_sel),
    .cfg_target_is_virtual(u_cfg_access_if.cfg_target_is_virtual),
    .cfg_virt_func_offset(u_cfg_access_if.cfg_virt_func_offset), .din(u_cfg_access_if.din),
    .dout(u_cfg_access_if.dout), .ack(u_cfg_access_if.ack), .ready(u_cfg_access_if.ready));
  // 100 MHz clock
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // counts and verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // bounded wait at falling edges: 0 ready, 1 response, 2 clear active
  task automatic await(input int w, input string what);
    for (int i = 0; i < 80; i++) begin
      if ((w == 0 && rdy === 1'b1) || (w == 1 && rv === 1'b1) || (w == 2 && rst_act === 1'b1))
        return;
      @(negedge clk);
    end
    n_mismatch++;
    $display("[FAIL] wait %s expected 1 seen 0", what);
    final_report;
  endtask
  // one access through the requester, response checked
  task automatic acc(input logic wr, input logic [11:0] a, input logic [0:0] p, input logic v,
      input logic [10:0] f, input logic [31:0] wd, input logic ee, input logic [31:0] exp,
      input string what);
    {valid, write, addr, pf, virt, vf, wdata} = {1'b1, wr, a, p, v, f, wd};
    await(0, "ready");
    @(posedge clk);
    @(negedge clk);
    valid = 1'b0;
    await(1, "response");
    `CHK({what, " error"}, ee, rerr)
    if (!wr && !ee) `CHK(what, exp, rdata)
    @(negedge clk);
    $display("test %s done", what);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    await(0, "ready after reset");
    `CHK("clear off", 1'b0, rst_act)
    // soft reset must be ignored while not selected
    soft_n = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("soft ignored", 1'b1, core_n)
    soft_n = 1'b1;
    await(0, "ready after soft");
    acc(0, 12'h003, 0, 0, 0, 0, 0, ID_WORD, "id");
    acc(1, 12'h006, 0, 0, 0, 32'hffff_ffff, 0, 0, "cmd wr");
    acc(0, 12'h004, 0, 0, 0, 0, 0, 32'h0000_0547, "cmd rd");
    acc(1, 12'h078, 1, 1, 3, 32'hffff_ffff, 0, 0, "vf wr");
    acc(0, 12'h078, 1, 1, 3, 0, 0, 32'h0000_7fff, "vf rd");
    acc(0, 12'h078, 1, 1, 2, 0, 0, 0, "vf other");
    acc(0, 12'h078, 1, 0, 0, 0, 0, 0, "parent");
    acc(1, 12'h020, 0, 0, 0, 32'h1234_5678, 0, 0, "log wr");
    acc(0, 12'h020, 0, 0, 0, 0, 0, 32'h1234_5678, "log rd");
    acc(0, 12'h078, 1, 1, 4, 0, 1, 0, "vf range");
    // pin reset, soft reset, hard controller clear
    for (int k = 0; k < 3; k++) begin
      acc(1, 12'h01c, 0, 0, 0, 32'ha5a5_0000 | k, 0, 0, "log fill");
      if (k == 0) pin_n = 1'b0;
      else if (k == 1) {use_soft, soft_n} = 2'b10;
      else {col, img} = 2'b11;
      await(2, "clear");
      repeat (2) @(negedge clk);
      `CHK("core reset", (k == 2), core_n)
      `CHK("ready in clear", 1'b0, rdy)
      // image-loaded level stays high: the hard clear must still end
      {pin_n, use_soft, soft_n} = 3'b101;
      await(0, "ready after clear");
      acc(0, 12'h01c, 0, 0, 0, 0, 0, 0, "log cleared");
      {col, img} = 2'b00;
    end
    final_report;
  end
endmodule
